// ---- pkg/rfpr_map.svh ----
// Register offsets, field positions and reset values for the partition registers.
`ifndef RFPR_MAP_SVH
`define RFPR_MAP_SVH

// Byte offsets of the three registers on the APB bus.
`define RFPR_KPB_OFFSET 12'h000
`define RFPR_DRS_OFFSET 12'h004
`define RFPR_UPB_OFFSET 12'h008

// Writable field of the kernel program base register.
`define RFPR_KPB_MSB 15
`define RFPR_KPB_LSB 10
`define RFPR_KPB_W 6

// Writable field of the user program base register.
`define RFPR_UPB_MSB 19
`define RFPR_UPB_LSB 11
`define RFPR_UPB_W 9

// Reset values of the writable fields.
`define RFPR_KPB_RESET 6'h00
`define RFPR_UPB_RESET 9'h000

// Default fixed data RAM size in bytes (32 KB).
`define RFPR_DRS_DEFAULT 32'h0000_8000

`endif

// ---- pkg/rfpr_pkg.sv ----
// Types shared by the partition register block.
package rfpr_pkg;

    // One APB request as seen by the slave.
    typedef struct packed {
        logic        sel;
        logic        enable;
        logic        write;
        logic [11:0] addr;
        logic [31:0] wdata;
    } rfpr_apb_req_s;

    // Partition boundaries handed to the bus matrix.
    typedef struct packed {
        logic [31:0] kernel_prog_base;
        logic [31:0] user_prog_base;
    } rfpr_bounds_s;

endpackage

// ---- hdl/rfpr_regs.sv ----
// APB register block holding the RAM and flash partition boundaries.
`timescale 1ns/10ps
`include "rfpr_map.svh"

// Functional notes
// - Kernel base bits 31:16 read zero.
// - Kernel base bits 15:10 writable partition offset.
// - Kernel base bits 9:0 fixed zero.
// - Reset clears partition base registers.
// - RAM size register read-only fixed value.
// - User base bits 31:20 read zero.
// - User base bits 19:11 writable, reset zero.
// - User base bits 10:0 fixed zero.
module rfpr_regs #(
    parameter logic [31:0] DATA_RAM_SIZE = `RFPR_DRS_DEFAULT // Fixed size.
) (
    input wire logic pclk, // System clock, 100 MHz.
    input wire logic presetn, // Asynchronous reset, active low.
    input wire logic psel, // APB select.
    input wire logic penable, // APB access phase.
    input wire logic pwrite, // APB direction, high for write.
    input wire logic [11:0] paddr, // APB byte address.
    input wire logic [31:0] pwdata, // APB write data.
    input wire logic [3:0] pstrb, // APB byte strobes.
    output logic [31:0] prdata, // APB read data.
    output logic pready, // APB ready, always high.
    output logic pslverr, // APB error for unmapped access or a write to the RAM size.
    output rfpr_pkg::rfpr_bounds_s bounds // Partition boundaries.
);

    // Bundled request, for readability.
    rfpr_pkg::rfpr_apb_req_s req;
    // Register state and next values.
    logic [`RFPR_KPB_W-1:0] kpb_reg; // Kernel program base field.
    logic [`RFPR_KPB_W-1:0] kpb_next; // Its next value.
    logic [`RFPR_UPB_W-1:0] upb_reg; // User program base field.
    logic [`RFPR_UPB_W-1:0] upb_next; // Its next value.
    logic [31:0] rdata_reg; // Registered read data.
    logic [31:0] rdata_next; // Its next value.
    logic err_reg; // Registered error flag.
    logic err_next; // Its next value.
    logic setup; // Setup phase of a transfer.
    logic access; // Access phase of a transfer.
    logic hit_kpb; // Address selects the kernel base.
    logic hit_drs; // Address selects the RAM size.
    logic hit_upb; // Address selects the user base.
    logic [31:0] kpb_word; // Full kernel base word.
    logic [31:0] upb_word; // Full user base word.

    assign req = '{sel: psel, enable: penable, write: pwrite,
                   addr: paddr, wdata: pwdata};
    assign setup = req.sel & ~req.enable;
    assign access = req.sel & req.enable;
    assign hit_kpb = (req.addr == `RFPR_KPB_OFFSET);
    assign hit_drs = (req.addr == `RFPR_DRS_OFFSET);
    assign hit_upb = (req.addr == `RFPR_UPB_OFFSET);

    // Place the stored fields in their word, every other bit zero.
    always_comb begin
        kpb_word = 32'h0000_0000;
        kpb_word[`RFPR_KPB_MSB:`RFPR_KPB_LSB] = kpb_reg;
        upb_word = 32'h0000_0000;
        upb_word[`RFPR_UPB_MSB:`RFPR_UPB_LSB] = upb_reg;
    end

    // Writes land only in the writable fields, honouring byte strobes.
    always_comb begin
        kpb_next = kpb_reg;
        upb_next = upb_reg;
        if (access && req.write) begin
            if (hit_kpb && pstrb[1]) begin
                kpb_next = req.wdata[`RFPR_KPB_MSB:`RFPR_KPB_LSB];
            end
            if (hit_upb) begin
                // Bits 15:11 sit in lane 1, bits 19:16 in lane 2.
                if (pstrb[1]) begin
                    upb_next[4:0] = req.wdata[15:11];
                end
                if (pstrb[2]) begin
                    upb_next[8:5] = req.wdata[19:16];
                end
            end
        end
    end

    // Read data and error are prepared in setup so they stand in access.
    always_comb begin
        rdata_next = rdata_reg;
        err_next = err_reg;
        if (setup) begin
            rdata_next = 32'h0000_0000;
            err_next = 1'b0;
            if (hit_kpb) begin
                rdata_next = req.write ? 32'h0000_0000 : kpb_word;
            end else if (hit_drs) begin
                // The size word is constant; writes are refused.
                rdata_next = req.write ? 32'h0000_0000 : DATA_RAM_SIZE;
                err_next = req.write;
            end else if (hit_upb) begin
                rdata_next = req.write ? 32'h0000_0000 : upb_word;
            end else begin
                // Unmapped addresses answer with an error.
                err_next = 1'b1;
            end
        end
    end

    // Register the partition fields; reset clears them.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            kpb_reg <= `RFPR_KPB_RESET;
            upb_reg <= `RFPR_UPB_RESET;
        end else begin
            kpb_reg <= kpb_next;
            upb_reg <= upb_next;
        end
    end

    // Register the read answer that the setup phase has prepared.
    // Keeping it apart from the fields lets each group hold its own reset.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata_reg <= 32'h0000_0000;
            err_reg <= 1'b0;
        end else begin
            rdata_reg <= rdata_next;
            err_reg <= err_next;
        end
    end

    // Zero wait states; error only shown in the access phase, read data held in rdata_reg.
    assign pready = 1'b1;
    assign prdata = rdata_reg;
    assign pslverr = access & err_reg;
    // Bounds to the matrix; software keeps them within the memory sizes.
    assign bounds = '{kernel_prog_base: kpb_word, user_prog_base: upb_word};

    // Low ten bits of the kernel base never rise, upper bits stay zero.
    kpb_fixed_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        bounds.kernel_prog_base[31:16] == 16'h0000 &&
        bounds.kernel_prog_base[9:0] == 10'h000)
        else $error("Kernel base fixed bits not zero.");

    // The user base keeps its unimplemented and fixed bits at zero.
    user_fixed_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        bounds.user_prog_base[31:20] == 12'h000 &&
        bounds.user_prog_base[10:0] == 11'h000)
        else $error("User base fixed bits not zero.");

    // A full write to the kernel base is seen on the next edge.
    sequence kpb_write_s;
        access && req.write && hit_kpb && pstrb[1];
    endsequence
    kpb_write_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        kpb_write_s |=> kpb_reg == $past(pwdata[15:10]))
        else $error("Kernel base write not stored.");

    // A write with both lanes on stores the whole user field.
    upb_write_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        access && req.write && hit_upb && pstrb[1] && pstrb[2]
        |=> upb_reg == $past(pwdata[19:11]))
        else $error("User base write not stored.");

    // A write with lane one off leaves the kernel field alone.
    kpb_lane_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        access && req.write && hit_kpb && !pstrb[1] |=> $stable(kpb_reg))
        else $error("Kernel base changed with its lane off.");

    // Lane two alone moves only the upper four bits of the user field.
    upb_lane_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        access && req.write && hit_upb && !pstrb[1] && pstrb[2]
        |=> upb_reg[4:0] == $past(upb_reg[4:0]) &&
        upb_reg[8:5] == $past(pwdata[19:16]))
        else $error("User base lane write wrong.");

    // Setup of a read from the size word, then its access phase.
    sequence drs_read_s;
        setup && !req.write && hit_drs ##1 access;
    endsequence
    // A read of the size word returns the fixed size.
    drs_read_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        drs_read_s |-> prdata == DATA_RAM_SIZE)
        else $error("RAM size read wrong.");

    // Setup of a write to the size word, then its access phase.
    sequence drs_write_s;
        setup && req.write && hit_drs ##1 access;
    endsequence
    // A write to the size word is refused and moves no field.
    drs_write_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        drs_write_s |-> pslverr ##1 $stable(kpb_reg) && $stable(upb_reg))
        else $error("RAM size write not refused.");

    // Setup of a read from the kernel base, then its access phase.
    sequence kpb_read_s;
        setup && !req.write && hit_kpb ##1 access;
    endsequence
    // The kernel base reads back with its fixed bits at zero.
    kpb_read_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        kpb_read_s |-> prdata[31:16] == 16'h0000 && prdata[9:0] == 10'h000)
        else $error("Kernel base read shows fixed bits.");

    // Setup of a read from the user base, then its access phase.
    sequence upb_read_s;
        setup && !req.write && hit_upb ##1 access;
    endsequence
    // The user base reads back with its fixed bits at zero.
    upb_read_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        upb_read_s |-> prdata[31:20] == 12'h000 && prdata[10:0] == 11'h000)
        else $error("User base read shows fixed bits.");

    // Fields hold when no write is in its access phase.
    hold_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        !(access && req.write) |=> $stable(kpb_reg) && $stable(upb_reg))
        else $error("Partition field changed without write.");

    // The first edge after reset leaves both fields cleared.
    reset_clear_a: assert property (
        @(posedge pclk)
        $rose(presetn) |-> kpb_reg == `RFPR_KPB_RESET &&
        upb_reg == `RFPR_UPB_RESET)
        else $error("Partition fields not cleared by reset.");

    // Setup at an address that no register decodes, then its access.
    sequence unmapped_s;
        setup && !hit_kpb && !hit_drs && !hit_upb ##1 access;
    endsequence
    // Unmapped access raises an error in its access phase.
    unmapped_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        unmapped_s |-> pslverr)
        else $error("Unmapped access gave no error.");

endmodule

// ---- dv/tb_top.sv ----
// Self-checking bench for the partition register block over APB.
`timescale 1ns/10ps
`include "rfpr_map.svh"
// Compares an observed value with the expected one and counts the result.
`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin \
    err_count++; $display("unexpected %s exp %h got %h", nm, ex, got); end end
module tb_top;
    // Largest valid size, so every kernel base written stays within it.
    localparam logic [31:0] RAM_SZ = 32'h0001_0000; // Data RAM size.
    logic pclk = 1'b0; // System clock.
    logic presetn = 1'b0; // Reset, active low.
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0; // APB controls.
    logic [11:0] paddr = 12'h000; // APB address.
    logic [31:0] pwdata = 32'h0000_0000; // APB write data.
    logic [3:0] pstrb = 4'hf; // All byte lanes enabled.
    logic [31:0] prdata; // APB read data.
    logic pready, pslverr; // APB answer.
    rfpr_pkg::rfpr_bounds_s bounds; // Boundaries seen by the matrix.
    int err_count = 0; // Mismatches seen.
    int checked = 0; // Comparisons made.
    rfpr_regs #(.DATA_RAM_SIZE(RAM_SZ)) u_rfpr_regs (.pclk(pclk),
        .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .bounds(bounds));
    // The clock toggles every 5 ns, half of its 10 ns period.
    initial begin
        forever #5 pclk = ~pclk;
    end
    // Prints the counts and the verdict, then ends the run.
    task automatic close_out();
        $display("checks %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // One APB transfer; the answer is taken at the edge where pready is
    // seen high, then penable falls and psel stays for a following setup.
    task automatic xfer(input logic is_wr, input logic [11:0] a,
        input logic [31:0] d, output logic [31:0] rd, output logic er);
        psel <= 1'b1;
        pwrite <= is_wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        penable <= 1'b0;
    endtask
    // Releases the bus for one cycle; penable is already low.
    task automatic idle();
        psel <= 1'b0;
        @(posedge pclk);
    endtask
    // Write with an expected error response.
    task automatic wr(input logic [11:0] a, input logic [31:0] d,
        input logic ee);
        logic [31:0] rd;
        logic er;
        xfer(1'b1, a, d, rd, er);
        `CHK("write error", ee, er)
    endtask
    // Read with expected data and error response.
    task automatic rc(input logic [11:0] a, input logic [31:0] ex,
        input logic ee);
        logic [31:0] rd;
        logic er;
        xfer(1'b0, a, 32'h0000_0000, rd, er);
        `CHK("read data", ex, rd)
        `CHK("read error", ee, er)
    endtask
    // Applies reset for four cycles.
    task automatic do_reset();
        presetn <= 1'b0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
    endtask
    // Main sequence of tests.
    initial begin
        do_reset();
        rc(`RFPR_KPB_OFFSET, 32'h0000_0000, 1'b0);
        rc(`RFPR_DRS_OFFSET, RAM_SZ, 1'b0);
        rc(`RFPR_UPB_OFFSET, 32'h0000_0000, 1'b0);
        idle();
        `CHK("bounds", 64'h0, bounds)
        $display("test reset values done");
        // User bases written stay below 1 MB, within any flash size.
        wr(`RFPR_KPB_OFFSET, 32'hffff_ffff, 1'b0);
        wr(`RFPR_UPB_OFFSET, 32'hffff_ffff, 1'b0);
        rc(`RFPR_KPB_OFFSET, 32'h0000_fc00, 1'b0);
        rc(`RFPR_UPB_OFFSET, 32'h000f_f800, 1'b0);
        idle();
        `CHK("bounds", {32'h0000_fc00, 32'h000f_f800}, bounds)
        wr(`RFPR_KPB_OFFSET, 32'hffff_a7ff, 1'b0);
        wr(`RFPR_UPB_OFFSET, 32'hfff5_0fff, 1'b0);
        idle();
        `CHK("bounds", {32'h0000_a400, 32'h0005_0800}, bounds)
        $display("test field masks done");
        pstrb <= 4'hd; // Lane one off, the other lanes on.
        wr(`RFPR_KPB_OFFSET, 32'h0000_0000, 1'b0);
        wr(`RFPR_UPB_OFFSET, 32'h0000_0000, 1'b0);
        idle();
        pstrb <= 4'hf; // All lanes on again.
        `CHK("bounds", {32'h0000_a400, 32'h0000_0800}, bounds)
        rc(`RFPR_KPB_OFFSET, 32'h0000_a400, 1'b0);
        rc(`RFPR_UPB_OFFSET, 32'h0000_0800, 1'b0);
        idle();
        $display("test byte lanes done");
        wr(`RFPR_DRS_OFFSET, 32'hffff_ffff, 1'b1);
        rc(`RFPR_DRS_OFFSET, RAM_SZ, 1'b0);
        rc(12'h010, 32'h0000_0000, 1'b1);
        idle();
        $display("test read-only and unmapped done");
        do_reset();
        rc(`RFPR_KPB_OFFSET, 32'h0000_0000, 1'b0);
        rc(`RFPR_UPB_OFFSET, 32'h0000_0000, 1'b0);
        idle();
        `CHK("bounds", 64'h0, bounds)
        $display("test second reset done");
        close_out();
    end
    // Cuts a hang short well beyond the expected run length.
    initial begin
        repeat (2000) @(posedge pclk);
        err_count++;
        close_out();
    end
endmodule
